// file: common/tpb_defs.svh
// register map, field positions, reset values and pattern constants for the prbs tester
`ifndef TPB_DEFS_SVH
`define TPB_DEFS_SVH

`define TPB_STREAMS 32
`define TPB_ADDR_MODE 14'h0001
`define TPB_ADDR_CTRL_BASE 14'h0100
`define TPB_ADDR_START_BASE 14'h0120
`define TPB_ADDR_LEN_BASE 14'h0140
`define TPB_ADDR_ERR_BASE 14'h0160
`define TPB_MODE_RX_EN_BIT 5
`define TPB_MODE_TX_EN_BIT 4
`define TPB_CTRL_CLR_BIT 1
`define TPB_CTRL_EN_BIT 0
`define TPB_MODE_RESET 16'h0000
`define TPB_PRBS_LEN 15
`define TPB_PRBS_SEED 15'h7fff
`define TPB_LOCK_FILL 4'he
`define TPB_ERR_MAX 16'hffff

`endif

// file: common/tpb_pkg.sv
// types shared by the prbs tester top and its per-stream lane
`include "tpb_defs.svh"
package tpb_pkg;

   // per-stream configuration handed to each lane
   typedef struct packed {
      logic rx_glob;
      logic tx_glob;
      logic enable;
      logic clr;
      logic [7:0] start;
      logic [8:0] len;
   } tpb_lane_cfg_t;

   typedef struct packed {
      logic [`TPB_PRBS_LEN-1:0] tx_lfsr;
      logic tx_bit;
      logic [`TPB_PRBS_LEN-1:0] ref_lfsr;
      logic [3:0] fill;
      logic locked;
      logic [15:0] err;
   } tpb_lane_st_t;

   typedef struct packed {
      logic [15:0] mode;
      logic [`TPB_STREAMS-1:0] en;
      logic [`TPB_STREAMS-1:0] clr;
      logic [`TPB_STREAMS-1:0][7:0] start;
      logic [`TPB_STREAMS-1:0][8:0] len;
      logic [2:0] wr_s;
      logic [2:0] rd_s;
      logic [15:0] rdata;
      logic rd_oe;
   } tpb_top_st_t;

endpackage

// file: hw/tpb_lane.sv
// one stream's pattern transmitter and pattern checker with saturating error count
`timescale 1ns/1ps
`include "tpb_defs.svh"
module tpb_lane (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // frame and channel timing
   input wire logic bit_en_i,
   input wire logic [7:0] chan_i,
   // stream data
   input wire logic rx_bit_i,
   input wire logic tx_insert_i,
   output logic tx_bit_o,
   // control and status
   input wire tpb_pkg::tpb_lane_cfg_t cfg_i,
   output logic locked_o,
   output logic [15:0] err_o
);
   tpb_pkg::tpb_lane_st_t s_r, s_nxt;
   logic in_win;
   logic rx_on;
   logic exp_raw;
   logic miss;
   logic [8:0] offs;

   assign rx_on = cfg_i.rx_glob & cfg_i.enable;
   assign offs = 9'(chan_i) - 9'(cfg_i.start);
   // contiguous window only; start to start+len-1
   assign in_win = rx_on & (chan_i >= cfg_i.start) & (offs < cfg_i.len);
   assign exp_raw = s_r.ref_lfsr[14] ^ s_r.ref_lfsr[13];
   // line carries the inverted generator output
   assign miss = (~rx_bit_i) != exp_raw;

   always_comb begin
      s_nxt = s_r;
      if (cfg_i.tx_glob && bit_en_i && tx_insert_i) begin
         s_nxt.tx_lfsr = {s_r.tx_lfsr[13:0], s_r.tx_lfsr[14] ^ s_r.tx_lfsr[13]};
         s_nxt.tx_bit = ~(s_r.tx_lfsr[14] ^ s_r.tx_lfsr[13]);
      end
      if (s_nxt.tx_lfsr == '0) begin
         s_nxt.tx_lfsr = `TPB_PRBS_SEED;
      end
      // clear first, so a same-cycle error still counts
      if (cfg_i.clr) begin
         s_nxt.err = 16'h0000;
      end
      if (!rx_on) begin
         s_nxt.locked = 1'b0;
         s_nxt.fill = 4'h0;
      end else if (bit_en_i && in_win) begin
         if (!s_r.locked) begin
            // seed reference from the line, reference then keeps running frame to frame
            s_nxt.ref_lfsr = {s_r.ref_lfsr[13:0], ~rx_bit_i};
            s_nxt.fill = s_r.fill + 4'h1;
            s_nxt.locked = (s_r.fill == `TPB_LOCK_FILL);
         end else begin
            s_nxt.ref_lfsr = {s_r.ref_lfsr[13:0], exp_raw};
            if (miss && s_nxt.err != `TPB_ERR_MAX) begin
               s_nxt.err = s_nxt.err + 16'h0001;
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         s_r <= '{tx_lfsr: `TPB_PRBS_SEED, tx_bit: 1'b1, ref_lfsr: '0, fill: 4'h0,
                  locked: 1'b0, err: 16'h0000};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign tx_bit_o = s_r.tx_bit;
   assign locked_o = s_r.locked;
   assign err_o = s_r.err;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   chk_err_saturate: assert property (s_r.err == `TPB_ERR_MAX && !cfg_i.clr |=>
      s_r.err == `TPB_ERR_MAX) else $error("error count left saturation");
   chk_err_clear: assert property (cfg_i.clr |=> s_r.err <= 16'h0001)
      else $error("error count not cleared");
   chk_err_step: assert property (!cfg_i.clr |=>
      (s_r.err == $past(s_r.err)) || (s_r.err == $past(s_r.err) + 16'h0001))
      else $error("error count jumped");
   chk_err_window: assert property (!(bit_en_i && in_win && s_r.locked) && !cfg_i.clr
      |=> $stable(s_r.err)) else $error("error counted outside window");
   chk_rx_gated: assert property (!rx_on |=> !s_r.locked && s_r.fill == 4'h0)
      else $error("checker active while disabled");
   chk_tx_gated: assert property (!cfg_i.tx_glob |=> $stable(s_r.tx_lfsr))
      else $error("transmitter ran while disabled");
   chk_lock_fill: assert property ($rose(s_r.locked) |-> $past(s_r.fill) == `TPB_LOCK_FILL)
      else $error("locked before fifteen bits");
endmodule

// file: hw/tpb_top.sv
// prbs bit error test block: microprocessor register port and thirty-two stream lanes
`timescale 1ns/1ps
`include "tpb_defs.svh"
module tpb_top #(
   parameter int NUM_STREAMS = `TPB_STREAMS
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // microprocessor port, asynchronous strobes
   input wire logic cpu_cs_n_i,
   input wire logic cpu_rd_n_i,
   input wire logic cpu_wr_n_i,
   input wire logic [13:0] cpu_addr_i,
   input wire logic [15:0] cpu_data_i,
   output logic [15:0] cpu_data_o,
   output logic cpu_data_oe_o,
   // switch frame and channel timing
   input wire logic bit_en_i,
   input wire logic [7:0] chan_i,
   // streams
   input wire logic [NUM_STREAMS-1:0] rx_bits_i,
   input wire logic [NUM_STREAMS-1:0] tx_insert_i,
   output logic [NUM_STREAMS-1:0] serial_output_streams_o,
   output logic [NUM_STREAMS-1:0] checker_locked_o
);
   localparam logic [2:0] REG_NONE = 3'h0;
   localparam logic [2:0] REG_MODE = 3'h1;
   localparam logic [2:0] REG_CTRL = 3'h2;
   localparam logic [2:0] REG_START = 3'h3;
   localparam logic [2:0] REG_LEN = 3'h4;
   localparam logic [2:0] REG_ERR = 3'h5;

   // refused at elaboration: lanes beyond the register map cannot be reached
   if (NUM_STREAMS < 1 || NUM_STREAMS > `TPB_STREAMS) begin : gen_bad_streams
      $error("NUM_STREAMS out of range");
   end

   tpb_pkg::tpb_top_st_t s_r, s_nxt;
   logic [`TPB_STREAMS-1:0][15:0] err_w;
   logic wr_go;
   logic rd_go;
   logic [2:0] reg_kind;
   logic [4:0] reg_idx;

   // sorts an address into register kind; stream index is its low five bits
   function automatic logic [2:0] tpb_region(input logic [13:0] a);
      logic [13:0] base;
      logic [2:0] kind;
      base = {a[13:5], 5'h00};
      kind = REG_NONE;
      if (a == `TPB_ADDR_MODE) begin
         kind = REG_MODE;
      end else if (32'(a[4:0]) < NUM_STREAMS) begin
         case (base)
            `TPB_ADDR_CTRL_BASE: kind = REG_CTRL;
            `TPB_ADDR_START_BASE: kind = REG_START;
            `TPB_ADDR_LEN_BASE: kind = REG_LEN;
            `TPB_ADDR_ERR_BASE: kind = REG_ERR;
            default: kind = REG_NONE;
         endcase
      end
      return kind;
   endfunction

   assign reg_kind = tpb_region(cpu_addr_i);
   assign reg_idx = cpu_addr_i[4:0];
   // address and data are stable while the strobe is held, so only strobes are synchronised
   assign wr_go = s_r.wr_s[1] & ~s_r.wr_s[2];
   assign rd_go = s_r.rd_s[1] & ~s_r.rd_s[2];

   always_comb begin
      s_nxt = s_r;
      s_nxt.wr_s = {s_r.wr_s[1:0], ~cpu_cs_n_i & ~cpu_wr_n_i};
      s_nxt.rd_s = {s_r.rd_s[1:0], ~cpu_cs_n_i & ~cpu_rd_n_i};
      s_nxt.clr = '0;
      s_nxt.rd_oe = s_r.rd_s[1];
      if (wr_go) begin
         case (reg_kind)
            REG_MODE: s_nxt.mode = cpu_data_i;
            REG_CTRL: begin
               s_nxt.en[reg_idx] = cpu_data_i[`TPB_CTRL_EN_BIT];
               s_nxt.clr[reg_idx] = cpu_data_i[`TPB_CTRL_CLR_BIT];
            end
            REG_START: s_nxt.start[reg_idx] = cpu_data_i[7:0];
            REG_LEN: s_nxt.len[reg_idx] = cpu_data_i[8:0];
            default: s_nxt.mode = s_r.mode; // error count ignores writes
         endcase
      end
      if (rd_go) begin
         case (reg_kind)
            REG_MODE: s_nxt.rdata = s_r.mode;
            REG_CTRL: s_nxt.rdata = {15'h0000, s_r.en[reg_idx]};
            REG_START: s_nxt.rdata = {8'h00, s_r.start[reg_idx]};
            REG_LEN: s_nxt.rdata = {7'h00, s_r.len[reg_idx]};
            REG_ERR: s_nxt.rdata = err_w[reg_idx];
            default: s_nxt.rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         s_r <= '{mode: `TPB_MODE_RESET, en: '0, clr: '0, start: '0, len: '0, wr_s: 3'h0,
                  rd_s: 3'h0, rdata: 16'h0000, rd_oe: 1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign cpu_data_o = s_r.rdata;
   assign cpu_data_oe_o = s_r.rd_oe;

   genvar g;
   generate
      for (g = 0; g < `TPB_STREAMS; g++) begin : gen_lane
         if (g < NUM_STREAMS) begin : gen_on
            tpb_pkg::tpb_lane_cfg_t cfg;
            // one assignment for the whole struct keeps it single-driven
            assign cfg = '{rx_glob: s_r.mode[`TPB_MODE_RX_EN_BIT],
                           tx_glob: s_r.mode[`TPB_MODE_TX_EN_BIT], enable: s_r.en[g],
                           clr: s_r.clr[g], start: s_r.start[g], len: s_r.len[g]};
            // lane g pairs input stream g with output stream g
            tpb_lane u_lane (
               .clk_i(clk_i),
               .rst_n_i(rst_n_i),
               .bit_en_i(bit_en_i),
               .chan_i(chan_i),
               .rx_bit_i(rx_bits_i[g]),
               .tx_insert_i(tx_insert_i[g]),
               .tx_bit_o(serial_output_streams_o[g]),
               .cfg_i(cfg),
               .locked_o(checker_locked_o[g]),
               .err_o(err_w[g])
            );
         end else begin : gen_off
            assign err_w[g] = 16'h0000;
         end
      end
   endgenerate

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   chk_mode_reset: assert property ($rose(rst_n_i) |->
      !s_r.mode[`TPB_MODE_RX_EN_BIT] && !s_r.mode[`TPB_MODE_TX_EN_BIT])
      else $error("global enables set after reset");
   chk_clr_pulse: assert property (s_r.clr != '0 |=> s_r.clr == '0)
      else $error("clear held beyond one cycle");
   chk_ctrl_write: assert property (wr_go && reg_kind == REG_CTRL |=>
      s_r.en[$past(reg_idx)] == $past(cpu_data_i[`TPB_CTRL_EN_BIT]))
      else $error("enable bit not written");
endmodule

// file: bench/tpb_far.sv
// far end: bit timing, insert window, one-frame loopback with error injection
`timescale 1ns/1ps
module tpb_far #(
   parameter int CH = 16
) (
   // bench control
   input wire logic clk_i,
   input wire logic [7:0] start_i,
   input wire logic [8:0] len_i,
   input wire logic [31:0] inj_i,
   input wire logic inj_go_i,
   input wire logic inv_i,
   output logic inj_used_o,
   output logic win_o,
   output logic bit_o,
   // device side
   input wire logic [31:0] so_i,
   output logic bit_en_o,
   output logic [7:0] chan_o,
   output logic [31:0] ins_o,
   output logic [31:0] rx_o
);
   logic [31:0] mem [CH*8];
   logic [31:0] f;
   int cnt = 0;
   logic w = 1'b0;
   // a bit slot every clock keeps saturation runs short
   // received bits pass unforced, only injected errors and the inv_i inversion make them differ
   assign bit_en_o = 1'b1;
   initial begin
      chan_o = 8'h00;
      ins_o = 32'h0;
      rx_o = 32'h0;
      inj_used_o = 1'b0;
   end
   always @(negedge clk_i) begin
      mem[cnt] <= so_i;
      win_o <= w;
      bit_o <= so_i[0];
      cnt = (cnt + 1) % (CH * 8);
      w = (cnt / 8 >= start_i) && (cnt / 8 < start_i + len_i);
      f = (inj_go_i && !inj_used_o && w) ? inj_i : 32'h0;
      chan_o <= 8'(cnt / 8);
      ins_o <= {32{w}};
      rx_o <= mem[cnt] ^ {32{inv_i}} ^ f;
      inj_used_o <= inj_go_i && (inj_used_o || w);
   end
endmodule

// file: bench/tb.sv
// self-checking bench: register port, loopback error runs, saturation
`timescale 1ns/1ps
`include "tpb_defs.svh"
`define C(a, b) begin samples_checked++; if ((a) !== (b)) begin n_fail++; \
   $display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end
module tb;
   localparam int FR = 128;
   localparam logic [13:0] CT = `TPB_ADDR_CTRL_BASE, SR = `TPB_ADDR_START_BASE;
   localparam logic [13:0] LN = `TPB_ADDR_LEN_BASE, ER = `TPB_ADDR_ERR_BASE;
   logic clk_i = 1'b0, rst_n_i = 1'b0, cs_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1;
   logic [13:0] addr = 14'h0;
   logic [15:0] wdat = 16'h0, rdat;
   logic [31:0] so, lock, ins, rx, inj = 32'h0, lf = 32'h3130;
   logic [7:0] chan, start = 8'h0;
   logic [8:0] len = 9'h1;
   logic oe, bit_en, used, win, bitw, go = 1'b0, inv = 1'b0, mon = 1'b0;
   logic [14:0] hist = 15'h0;
   logic [15:0] ex [32];
   int n_fail = 0, samples_checked = 0, cyc = 0, nh = 0;
   tpb_top i_dut (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .cpu_cs_n_i(cs_n), .cpu_rd_n_i(rd_n),
      .cpu_wr_n_i(wr_n), .cpu_addr_i(addr), .cpu_data_i(wdat), .cpu_data_o(rdat),
      .cpu_data_oe_o(oe), .bit_en_i(bit_en), .chan_i(chan), .rx_bits_i(rx),
      .tx_insert_i(ins), .serial_output_streams_o(so), .checker_locked_o(lock)
   );
   tpb_far #(.CH(16)) i_far (
      .clk_i(clk_i), .start_i(start), .len_i(len), .inj_i(inj), .inj_go_i(go),
      .inv_i(inv), .inj_used_o(used), .win_o(win), .bit_o(bitw), .so_i(so),
      .bit_en_o(bit_en), .chan_o(chan), .ins_o(ins), .rx_o(rx)
   );
   function automatic logic [31:0] nx(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   // next pattern bit from the last fifteen sent
   function automatic logic pb(input logic [14:0] h);
      return ~(h[13] ^ h[14]);
   endfunction
   initial begin
      forever #4 clk_i = ~clk_i;
   end
   // strobes are synchronised inside, so hold well past the three-edge latency
   task automatic acc(input logic w, input logic [13:0] a, input logic [15:0] d);
      @(negedge clk_i);
      addr = a;
      wdat = d;
      cs_n = 1'b0;
      rd_n = w;
      wr_n = !w;
      repeat (6) @(negedge clk_i);
      if (!w) `C(oe, 1'b1)
      cs_n = 1'b1;
      rd_n = 1'b1;
      wr_n = 1'b1;
      repeat (4) @(negedge clk_i);
   endtask
   task automatic wr(input logic [13:0] a, input logic [15:0] d);
      acc(1'b1, a, d);
   endtask
   task automatic rd(input logic [13:0] a, input logic [15:0] e);
      acc(1'b0, a, 16'h0);
      `C(rdat, e)
      `C(oe, 1'b0)
   endtask
   task automatic inject(input logic [31:0] m);
      inj <= m;
      go <= 1'b1;
      for (int i = 0; i < 300 && used !== 1'b1; i++) @(negedge clk_i);
      `C(used, 1'b1)
      go <= 1'b0;
      repeat (2) @(negedge clk_i);
   endtask
   task automatic wrap_up();
      $display("compares %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 90000) begin
         n_fail++;
         wrap_up();
      end
      if (mon && win) begin
         if (nh >= 15) `C(bitw, pb(hist))
         hist = {hist[13:0], bitw};
         nh++;
      end
   end
   initial begin
      repeat (16) @(negedge clk_i);
      rst_n_i = 1'b1;
      rd(`TPB_ADDR_MODE, `TPB_MODE_RESET);
      rd(ER + 14'h5, 16'h0);
      rd(14'h0180, 16'h0);
      lf = nx(lf);
      start <= 8'(lf % 12);
      len <= 9'(1 + (lf >> 8) % (16 - lf % 12));
      repeat (2 * FR) @(negedge clk_i);
      for (int s = 0; s < 32; s++) begin
         wr(SR + 14'(s), {8'h0, start});
         wr(LN + 14'(s), {7'h0, len});
         wr(CT + 14'(s), 16'h0001);
      end
      rd(SR + 14'h7, {8'h0, start});
      rd(LN + 14'h7, {7'h0, len});
      wr(`TPB_ADDR_MODE, 16'h0010);
      repeat (FR) @(negedge clk_i);
      mon = 1'b1;
      inject(32'hffffffff);
      repeat (FR) @(negedge clk_i);
      `C(lock, 32'h0)
      rd(ER + 14'h3, 16'h0);
      wr(`TPB_ADDR_MODE, 16'h0030);
      repeat (3 * FR) @(negedge clk_i);
      `C(lock, 32'hffffffff)
      for (int s = 0; s < 32; s++) begin
         wr(CT + 14'(s), 16'h0003);
         ex[s] = 16'h0;
      end
      for (int k = 0; k < 6; k++) begin
         lf = nx(lf);
         inject(lf);
         for (int s = 0; s < 32; s++) ex[s] += 16'(lf[s]);
      end
      repeat (FR) @(negedge clk_i);
      for (int s = 0; s < 32; s++) rd(ER + 14'(s), ex[s]);
      wr(ER + 14'h2, 16'h1234);
      rd(ER + 14'h2, ex[2]);
      wr(CT + 14'h2, 16'h0003);
      rd(ER + 14'h2, 16'h0);
      rd(CT + 14'h2, 16'h0001);
      wr(LN + 14'h9, 16'h0100);
      rd(LN + 14'h9, 16'h0100);
      // full-frame window on stream 0, then every bit inverted
      wr(CT, 16'h0000);
      start <= 8'h0;
      len <= 9'h010;
      wr(SR, 16'h0000);
      wr(LN, 16'h0010);
      repeat (2 * FR) @(negedge clk_i);
      wr(CT, 16'h0003);
      repeat (FR) @(negedge clk_i);
      inv <= 1'b1;
      repeat (66000) @(negedge clk_i);
      inv <= 1'b0;
      rd(ER, 16'hffff);
      wrap_up();
   end
endmodule
